/* File: design/cpu_bus_cycle_sequencer.sv */
// Bus-cycle sequencer: turns per-cycle codes from decode into bus requests, resolves
// optional and conditional cycles, owns the page register and runs branch refills.
// Assumes the memory side raises stall_in for each extra or stretched bus cycle.
`timescale 1ns/10ps
module cpu_bus_cycle_sequencer
    import cycle_seq_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                nrst_in,
    input  wire logic                stall_in,
    input  wire logic                code_valid_in,
    input  wire cycle_code_t         code_in,
    input  wire logic                cond_active_in,
    input  wire logic                opt_fetch_in,
    input  wire logic                prebyte_in,
    input  wire logic                prebyte_misaligned_in,
    input  wire logic                branch_in,
    input  wire logic                branch_long_in,
    input  wire logic                branch_taken_in,
    input  wire logic [PAGE_W-1:0]   page_wdata_in,
    output bus_req_t                 req_out,
    output logic                     req_valid_out,
    output logic                     busy_out,
    output logic [PAGE_W-1:0]        page_rdata_out,
    output logic [PAGE_W-1:0]        program_page_register_out
);

    // Branch sequencer states; the destination is worked out alongside the first refill fetch.
    typedef enum logic [3:0] {
        BR_IDLE   = 4'b0001,
        BR_OPT1   = 4'b0010,
        BR_REFILL = 4'b0100,
        BR_OPT2   = 4'b1000
    } br_state_t;

    br_state_t        br_q;
    logic [1:0]       refill_cnt_q;
    logic             prebyte_fetched_q;
    logic             in_page2_q;
    logic [PAGE_W-1:0] program_page_register_q;
    logic             advance;

    // Everything but the page register advances only on un-stalled clocks, so a stretched bus cycle is invisible.
    assign advance = !stall_in;

    // Builds a request from the operation, width and stretch eligibility.
    function automatic bus_req_t make_req(input bus_op_t op, input logic word, input logic stretch);
        bus_req_t r;
        r             = REQ_IDLE;
        r.op          = op;
        r.word        = word;
        r.ext_visible = (op != OP_NONE);
        r.stretch_ok  = stretch;
        return r;
    endfunction : make_req

    // Resolves an optional cycle into a fetch or a free cycle.
    function automatic bus_req_t opt_req(input logic fetch);
        return fetch ? make_req(OP_FETCH, 1'b1, 1'b1) : REQ_IDLE;
    endfunction : opt_req

    // Maps one cycle code to its bus request when no branch is in progress.
    function automatic bus_req_t decode_code(input cycle_code_t c, input logic cond,
                                             input logic optf);
        bus_req_t r;
        r = REQ_IDLE;
        unique case (c)
            CYC_FREE:       r = REQ_IDLE;
            CYC_PROG:       r = make_req(OP_FETCH, 1'b1, 1'b1);
            CYC_OPT:        r = opt_req(optf);
            CYC_RD_BYTE:    r = make_req(OP_READ,  1'b0, 1'b1);
            CYC_RD_WORD:    r = make_req(OP_READ,  1'b1, 1'b1);
            CYC_WR_BYTE:    r = make_req(OP_WRITE, 1'b0, 1'b1);
            CYC_WR_WORD:    r = make_req(OP_WRITE, 1'b1, 1'b1);
            CYC_STK_BYTE:   r = make_req(OP_PUSH,  1'b0, 1'b1);
            CYC_STK_WORD:   r = make_req(OP_PUSH,  1'b1, 1'b1);
            CYC_UNSTK_BYTE: r = make_req(OP_POP,   1'b0, 1'b1);
            CYC_UNSTK_WORD: r = make_req(OP_POP,   1'b1, 1'b1);
            CYC_VECTOR:     r = make_req(OP_VECT,  1'b1, 1'b1);
            CYC_IND_PTR:    r = make_req(OP_READ,  1'b1, 1'b1);
            CYC_IND_PAGE:   r = make_req(OP_READ,  1'b0, 1'b1);
            CYC_COND_RD_B:  r = cond ? make_req(OP_READ, 1'b0, 1'b1) : REQ_IDLE;
            CYC_COND_RD_W:  r = cond ? make_req(OP_READ, 1'b1, 1'b1) : REQ_IDLE;
            CYC_COND_WR_B:  r = cond ? make_req(OP_WRITE, 1'b0, 1'b1) : REQ_IDLE;
            CYC_PAGE_RD: begin
                r         = REQ_IDLE;
                r.page_rd = 1'b1;
            end
            CYC_PAGE_WR: begin
                r         = REQ_IDLE;
                r.page_wr = 1'b1;
            end
            default:        r = REQ_IDLE;
        endcase
        return r;
    endfunction : decode_code

    // Optional-cycle resolution: the prebyte fetch and the later optional cycle alternate.
    bus_req_t code_req;
    always_comb begin
        bus_req_t r;
        r = decode_code(code_in, cond_active_in, opt_fetch_in);
        if (code_in == CYC_OPT) begin
            if (prebyte_in) begin
                r = opt_req(prebyte_misaligned_in);
            end else if (in_page2_q) begin
                r = opt_req(!prebyte_fetched_q);
            end
        end
        code_req = r;
    end

    // Branch state machine; a branch request takes priority over the ordinary code.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            br_q         <= BR_IDLE;
            refill_cnt_q <= 2'h0;
        end else if (advance) begin
            unique case (br_q)
                BR_IDLE: begin
                    if (code_valid_in && branch_in) begin
                        if (branch_long_in) begin
                            br_q <= BR_OPT1;
                        end else if (branch_taken_in) begin
                            br_q <= BR_REFILL;
                            refill_cnt_q <= 2'(REFILL_FETCHES - 2'h2);
                        end
                    end
                end
                // The first refill fetch goes out on leaving this state, so two remain to count.
                BR_OPT1: begin
                    if (branch_taken_in) begin
                        br_q         <= BR_REFILL;
                        refill_cnt_q <= 2'(REFILL_FETCHES - 2'h2);
                    end else begin
                        br_q <= BR_OPT2;
                    end
                end
                BR_REFILL: begin
                    if (refill_cnt_q == 2'h0) begin
                        br_q <= BR_IDLE;
                    end else begin
                        refill_cnt_q <= refill_cnt_q - 2'h1;
                    end
                end
                BR_OPT2: br_q <= BR_IDLE;
            endcase
        end
    end

    // Tracks whether the prebyte optional cycle fetched, for the second optional cycle.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prebyte_fetched_q <= 1'b0;
            in_page2_q        <= 1'b0;
        end else if (advance && code_valid_in && code_in == CYC_OPT) begin
            if (prebyte_in) begin
                prebyte_fetched_q <= prebyte_misaligned_in;
                in_page2_q        <= 1'b1;
            end else begin
                in_page2_q        <= 1'b0;
            end
        end
    end

    // Issues one request per advancing clock; held unchanged while stalled.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            req_out       <= REQ_IDLE;
            req_valid_out <= 1'b0;
        end else if (advance) begin
            req_valid_out <= code_valid_in || (br_q != BR_IDLE);
            unique case (br_q)
                BR_IDLE: begin
                    if (code_valid_in && branch_in && branch_long_in) begin
                        req_out <= opt_req(prebyte_misaligned_in);
                    end else if (code_valid_in && branch_in) begin
                        // Taken or not, a short branch fetches in its own cycle; taken starts the refill.
                        req_out <= make_req(OP_FETCH, 1'b1, 1'b1);
                    end else begin
                        req_out <= code_valid_in ? code_req : REQ_IDLE;
                    end
                end
                BR_OPT1:   req_out <= make_req(OP_FETCH, 1'b1, 1'b1);
                BR_REFILL: req_out <= make_req(OP_FETCH, 1'b1, 1'b1);
                BR_OPT2:   req_out <= opt_req(!prebyte_fetched_q);
            endcase
        end
    end

    // Busy flag shows a branch sequence is running and new codes are ignored.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_out <= 1'b0;
        end else if (advance) begin
            // Busy follows the next branch state, so decode loses no slot after the last fetch.
            unique case (br_q)
                BR_IDLE:   busy_out <= code_valid_in && branch_in && (branch_long_in || branch_taken_in);
                BR_OPT1:   busy_out <= 1'b1;
                BR_REFILL: busy_out <= (refill_cnt_q != 2'h0);
                BR_OPT2:   busy_out <= 1'b0;
            endcase
        end
    end

    // Internal page register: its cycles never go to the pins and never stall.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            program_page_register_q <= PAGE_RST;
            page_rdata_out          <= PAGE_RST;
        end else begin
            if (code_valid_in && br_q == BR_IDLE && code_in == CYC_PAGE_WR) begin
                program_page_register_q <= page_wdata_in;
            end
            if (code_valid_in && br_q == BR_IDLE && code_in == CYC_PAGE_RD) begin
                page_rdata_out <= program_page_register_q;
            end
        end
    end

    assign program_page_register_out = program_page_register_q;

    // A free cycle drives no bus operation and is never stretch-eligible.
    a_free_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && code_valid_in && br_q == BR_IDLE && !branch_in && code_in == CYC_FREE)
        |=> (req_out.op == OP_NONE && !req_out.stretch_ok))
        else $error("free cycle produced a bus request");

    // Page cycles are invisible and not stretch-eligible.
    a_page_internal: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && code_valid_in && br_q == BR_IDLE && !branch_in &&
         (code_in == CYC_PAGE_RD || code_in == CYC_PAGE_WR))
        |=> (!req_out.ext_visible && !req_out.stretch_ok))
        else $error("page cycle became visible on the bus");

    // A page write lands in the register one clock later.
    a_page_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (code_valid_in && br_q == BR_IDLE && code_in == CYC_PAGE_WR)
        |=> program_page_register_q == $past(page_wdata_in))
        else $error("page register not written");

    // Read-word, pointer and vector codes yield word requests.
    a_word_width: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && code_valid_in && br_q == BR_IDLE && !branch_in &&
         (code_in == CYC_RD_WORD || code_in == CYC_IND_PTR || code_in == CYC_VECTOR))
        |=> req_out.word)
        else $error("word cycle issued as byte");

    // Byte codes yield byte requests, so the bus side never splits them.
    a_byte_width: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && code_valid_in && br_q == BR_IDLE && !branch_in &&
         (code_in == CYC_RD_BYTE || code_in == CYC_WR_BYTE || code_in == CYC_STK_BYTE ||
          code_in == CYC_UNSTK_BYTE || code_in == CYC_IND_PAGE))
        |=> !req_out.word)
        else $error("byte cycle issued as word");

    // A conditional cycle whose access is skipped leaves the bus free and unstretched.
    a_cond_free: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && code_valid_in && br_q == BR_IDLE && !branch_in && !cond_active_in &&
         (code_in == CYC_COND_RD_B || code_in == CYC_COND_RD_W || code_in == CYC_COND_WR_B))
        |=> (req_out.op == OP_NONE && !req_out.stretch_ok))
        else $error("skipped conditional cycle reached the bus");

    // A plain optional cycle that does not fetch acts as a free cycle and never stretches.
    a_opt_free: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && code_valid_in && br_q == BR_IDLE && !branch_in && code_in == CYC_OPT &&
         !opt_fetch_in && !prebyte_in && !in_page2_q)
        |=> (req_out.op == OP_NONE && !req_out.stretch_ok))
        else $error("free optional cycle became a bus request");

    // The prebyte optional cycle fetches exactly when the prebyte is misaligned.
    a_prebyte_opt: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && code_valid_in && br_q == BR_IDLE && code_in == CYC_OPT && prebyte_in &&
         (!branch_in || branch_long_in))
        |=> ((req_out.op == OP_FETCH) == $past(prebyte_misaligned_in)))
        else $error("prebyte optional cycle resolved wrongly");

    // Stall freezes the issued request.
    a_stall_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        stall_in |=> $stable(req_out))
        else $error("request changed during stall");

    // Busy mirrors the branch state, so a new code is welcome as soon as the branch ends.
    a_busy_state: assert property (@(posedge clk_in) disable iff (!nrst_in)
        busy_out == (br_q != BR_IDLE))
        else $error("busy flag out of step with branch state");

    // Every refill step is an aligned, stretch-eligible program word fetch.
    a_refill_word: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && br_q == BR_REFILL)
        |=> (req_out.op == OP_FETCH && req_out.word && req_out.stretch_ok))
        else $error("refill cycle was not a word fetch");

    sequence s_short_taken;
        advance && br_q == BR_IDLE && code_valid_in && branch_in && !branch_long_in && branch_taken_in;
    endsequence

    // Last two refill steps: two fetches seen so far, then a third and the machine is idle.
    sequence s_refill_tail;
        (req_out.op == OP_FETCH && $past(req_out.op) == OP_FETCH)
        ##1 (req_out.op == OP_FETCH && br_q == BR_IDLE);
    endsequence

    // Taken short branch: three fetches in three un-stalled cycles, the first in the branch cycle.
    a_short_taken: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_short_taken ##1 (!stall_in)[*2] |-> s_refill_tail)
        else $error("short branch taken timing wrong");

    // Taken long branch: the destination fetches start right after the prebyte cycle.
    a_long_taken: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && br_q == BR_OPT1 && branch_taken_in) |=> (req_out.op == OP_FETCH && br_q == BR_REFILL))
        else $error("long branch taken did not start its refill");

    sequence s_long_nt;
        advance && br_q == BR_OPT1 && !branch_taken_in;
    endsequence

    // Not-taken long branch: the queue advances with a fetch, then the trailing optional cycle.
    a_long_nt: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_long_nt |=> (req_out.op == OP_FETCH && br_q == BR_OPT2))
        else $error("long branch not-taken order wrong");

    // Second optional cycle inverts the prebyte decision.
    a_opt_alt: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (advance && br_q == BR_OPT2) |=> (req_out.op == OP_FETCH) == !$past(prebyte_fetched_q))
        else $error("second optional cycle did not alternate");

endmodule : cpu_bus_cycle_sequencer

/* File: design/cycle_seq_pkg.sv */
// Package for the bus-cycle sequencer: cycle codes, access widths and the bus request carrier.
// Assumes a single 125 MHz clock domain shared with the memory bus and its stretch logic.
package cycle_seq_pkg;

    // Cycle codes as they arrive from the instruction decode.
    typedef enum logic [4:0] {
        CYC_FREE       = 5'h00,
        CYC_PROG       = 5'h01,
        CYC_OPT        = 5'h02,
        CYC_RD_BYTE    = 5'h03,
        CYC_RD_WORD    = 5'h04,
        CYC_WR_BYTE    = 5'h05,
        CYC_WR_WORD    = 5'h06,
        CYC_STK_BYTE   = 5'h07,
        CYC_STK_WORD   = 5'h08,
        CYC_UNSTK_BYTE = 5'h09,
        CYC_UNSTK_WORD = 5'h0A,
        CYC_VECTOR     = 5'h0B,
        CYC_PAGE_RD    = 5'h0C,
        CYC_PAGE_WR    = 5'h0D,
        CYC_IND_PTR    = 5'h0E,
        CYC_IND_PAGE   = 5'h0F,
        CYC_COND_RD_B  = 5'h10,
        CYC_COND_RD_W  = 5'h11,
        CYC_COND_WR_B  = 5'h12
    } cycle_code_t;

    // Bus operations presented to the memory side.
    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_FETCH = 3'h1,
        OP_READ  = 3'h2,
        OP_WRITE = 3'h3,
        OP_PUSH  = 3'h4,
        OP_POP   = 3'h5,
        OP_VECT  = 3'h6
    } bus_op_t;

    // One bus request as issued for a single core cycle.
    typedef struct packed {
        bus_op_t op;
        logic    word;
        logic    ext_visible;
        logic    stretch_ok;
        logic    page_rd;
        logic    page_wr;
    } bus_req_t;

    // Request driven during reset and on free cycles.
    localparam bus_req_t REQ_IDLE = '{op: OP_NONE, word: 1'b0, ext_visible: 1'b0,
                                      stretch_ok: 1'b0, page_rd: 1'b0, page_wr: 1'b0};

    // Branch timing in core cycles.
    localparam logic [2:0] SHORT_TAKEN_CYC     = 3'h3;
    localparam logic [2:0] SHORT_NOT_TAKEN_CYC = 3'h1;
    localparam logic [2:0] LONG_TAKEN_CYC      = 3'h4;
    localparam logic [2:0] LONG_NOT_TAKEN_CYC  = 3'h3;
    localparam logic [1:0] REFILL_FETCHES      = 2'h3;

    // Width of the page register.
    localparam int unsigned PAGE_W   = 8;
    localparam logic [7:0]  PAGE_RST = 8'h00;

endpackage : cycle_seq_pkg

/* File: dv/mem_bus_model.sv */
// Behavioural model of the system memory bus with external-bus and chip-select stretching.
// Assumes the sequencer's request is registered and stands until the next un-stalled edge.
`timescale 1ns/10ps
module mem_bus_model
    import cycle_seq_pkg::*;
#(
    parameter int SLOW_WAIT = 2
)
(
    input  wire logic     clk_in,
    input  wire logic     nrst_in,
    input  wire bus_req_t req_in,
    input  wire logic     narrow_in,
    input  wire logic     slow_in,
    output logic          stall_out
);
    logic [3:0] waited_q;
    logic [3:0] extra;

    // Extra bus cycles for the current request; internal or free cycles never stretch.
    always_comb begin
        extra = 4'h0;
        if (req_in.ext_visible && req_in.stretch_ok) begin
            extra = {3'h0, req_in.word & narrow_in} + (slow_in ? 4'(SLOW_WAIT) : 4'h0);
        end
    end

    // One stall level freezes the core clock enable for every extra cycle.
    assign stall_out = (waited_q < extra);

    // The count restarts at each un-stalled edge, so identical back-to-back requests stretch alike.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            waited_q <= 4'h0;
        end else if (stall_out) begin
            waited_q <= waited_q + 4'h1;
        end else begin
            waited_q <= 4'h0;
        end
    end
endmodule : mem_bus_model

/* File: dv/test_cpu_bus_cycle_sequencer.sv */
// Self-checking bench for the bus-cycle sequencer, with the memory bus model on its far side.
// Assumes the package cycle codes and the registered one-clock answer of the sequencer.
`timescale 1ns/10ps
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module test_cpu_bus_cycle_sequencer;
    import cycle_seq_pkg::*;
    localparam int SLOW = 2;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        stall_in;
    logic        code_valid_in = 1'b0;
    cycle_code_t code_in = CYC_FREE;
    logic        cond_active_in = 1'b0;
    logic        opt_fetch_in = 1'b0;
    logic        prebyte_in = 1'b0;
    logic        prebyte_misaligned_in = 1'b0;
    logic        branch_in = 1'b0;
    logic        branch_long_in = 1'b0;
    logic        branch_taken_in = 1'b0;
    logic [7:0]  page_wdata_in = 8'h00;
    logic        narrow = 1'b0;
    logic        slow = 1'b0;
    bus_req_t    req_out;
    logic        req_valid_out;
    logic        busy_out;
    logic [7:0]  page_rdata_out;
    logic [7:0]  program_page_register_out;
    int          failures = 0;
    int          n_checks = 0;

    // Free-running 125 MHz clock.
    always #4 clk_in = ~clk_in;

    cpu_bus_cycle_sequencer DUT (.clk_in(clk_in), .nrst_in(nrst_in), .stall_in(stall_in),
        .code_valid_in(code_valid_in), .code_in(code_in), .cond_active_in(cond_active_in),
        .opt_fetch_in(opt_fetch_in), .prebyte_in(prebyte_in), .prebyte_misaligned_in(prebyte_misaligned_in),
        .branch_in(branch_in), .branch_long_in(branch_long_in), .branch_taken_in(branch_taken_in),
        .page_wdata_in(page_wdata_in), .req_out(req_out), .req_valid_out(req_valid_out), .busy_out(busy_out),
        .page_rdata_out(page_rdata_out), .program_page_register_out(program_page_register_out));

    mem_bus_model #(.SLOW_WAIT(SLOW)) far_bus (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_out),
        .narrow_in(narrow), .slow_in(slow), .stall_out(stall_in));

    // Prints the verdict and ends the run.
    task give_verdict;
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // Waits until the next edge will accept a code, then returns at that edge.
    task automatic wait_ready;
        int i;
        for (i = 0; i < 20; i++) begin
            @(negedge clk_in);
            if (stall_in === 1'b0 && busy_out === 1'b0) break;
        end
        if (i == 20) begin
            failures++;
            give_verdict();
        end
        @(posedge clk_in);
    endtask : wait_ready

    // Presents one code and counts the stalled edges; the request must hold while frozen.
    task automatic issue(input cycle_code_t c, input logic cond, input logic optf, output int stalls);
        bus_req_t snap;
        wait_ready();
        code_in <= c;
        cond_active_in <= cond;
        opt_fetch_in <= optf;
        code_valid_in <= 1'b1;
        @(posedge clk_in);
        code_valid_in <= 1'b0;
        #1;
        snap = req_out;
        for (stalls = 0; stalls < 20 && stall_in === 1'b1; stalls++) begin
            @(posedge clk_in);
            #1;
            `CHK("held request", snap, req_out)
        end
        if (stalls == 20) begin
            failures++;
            give_verdict();
        end
    endtask : issue

    // One cycle code, first on a prompt bus, then on a narrow external bus under slow select.
    task automatic code_case(input cycle_code_t c, input logic cond, optf, input bus_op_t eop, input logic ew);
        int st;
        for (int m = 0; m < 2; m++) begin
            narrow <= m[0];
            slow <= m[0];
            issue(c, cond, optf, st);
            `CHK("op", eop, req_out.op)
            `CHK("word", ew, req_out.word)
            `CHK("visible", eop != OP_NONE, req_out.ext_visible)
            `CHK("stalls", (m == 1 && eop != OP_NONE) ? int'(ew) + SLOW : 0, st)
            if (eop != OP_NONE) `CHK("valid", 1'b1, req_valid_out)
        end
    endtask : code_case

    // Page register write then read; both stay internal even under slow select.
    task automatic page_case;
        int st;
        narrow <= 1'b1;
        slow <= 1'b1;
        page_wdata_in <= 8'hA5;
        issue(CYC_PAGE_WR, 1'b0, 1'b0, st);
        `CHK("page reg", 8'hA5, program_page_register_out)
        `CHK("page wr", 2'h1, {req_out.ext_visible, req_out.page_wr})
        `CHK("page wr stalls", 0, st)
        issue(CYC_PAGE_RD, 1'b0, 1'b0, st);
        `CHK("page rdata", 8'hA5, page_rdata_out)
        `CHK("page rd", 2'h1, {req_out.ext_visible, req_out.page_rd})
        `CHK("page rd stalls", 0, st)
    endtask : page_case

    // Prebyte optional cycle, then the instruction's own optional cycle, for both prebyte alignments.
    task automatic prebyte_case;
        int st;
        for (int m = 0; m < 2; m++) begin
            narrow <= 1'b0;
            slow <= 1'b0;
            prebyte_in <= 1'b1;
            prebyte_misaligned_in <= m[0];
            issue(CYC_OPT, 1'b0, 1'b1, st);
            `CHK("prebyte opt", m[0] ? OP_FETCH : OP_NONE, req_out.op)
            prebyte_in <= 1'b0;
            issue(CYC_OPT, 1'b0, 1'b1, st);
            `CHK("second opt", m[0] ? OP_NONE : OP_FETCH, req_out.op)
        end
    endtask : prebyte_case

    // Starts a branch and compares the ops of the following cycles.
    task automatic branch_case(input logic lng, taken, mis, input bus_op_t exp[6], input int n);
        narrow <= 1'b0;
        slow <= 1'b0;
        wait_ready();
        code_in <= lng ? CYC_OPT : CYC_PROG;
        prebyte_in <= lng;
        prebyte_misaligned_in <= mis;
        branch_in <= 1'b1;
        branch_long_in <= lng;
        branch_taken_in <= taken;
        code_valid_in <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            code_valid_in <= 1'b0;
            branch_in <= 1'b0;
            prebyte_in <= 1'b0;
            #1;
            `CHK("branch op", exp[i], req_out.op)
        end
        `CHK("busy end", 1'b0, busy_out)
    endtask : branch_case

    // Reset, then at least one scenario per cycle type and one per branch case.
    initial begin
        repeat (11) @(posedge clk_in);
        #1;
        `CHK("reset req", REQ_IDLE, req_out)
        `CHK("reset page", PAGE_RST, program_page_register_out)
        `CHK("reset busy", 1'b0, busy_out)
        @(posedge clk_in);
        nrst_in <= 1'b1;
        code_case(CYC_FREE, 1'b0, 1'b0, OP_NONE, 1'b0);
        code_case(CYC_PROG, 1'b0, 1'b0, OP_FETCH, 1'b1);
        code_case(CYC_OPT, 1'b0, 1'b1, OP_FETCH, 1'b1);
        code_case(CYC_OPT, 1'b0, 1'b0, OP_NONE, 1'b0);
        code_case(CYC_RD_BYTE, 1'b0, 1'b0, OP_READ, 1'b0);
        code_case(CYC_RD_WORD, 1'b0, 1'b0, OP_READ, 1'b1);
        code_case(CYC_WR_BYTE, 1'b0, 1'b0, OP_WRITE, 1'b0);
        code_case(CYC_WR_WORD, 1'b0, 1'b0, OP_WRITE, 1'b1);
        code_case(CYC_STK_BYTE, 1'b0, 1'b0, OP_PUSH, 1'b0);
        code_case(CYC_STK_WORD, 1'b0, 1'b0, OP_PUSH, 1'b1);
        code_case(CYC_UNSTK_BYTE, 1'b0, 1'b0, OP_POP, 1'b0);
        code_case(CYC_UNSTK_WORD, 1'b0, 1'b0, OP_POP, 1'b1);
        code_case(CYC_VECTOR, 1'b0, 1'b0, OP_VECT, 1'b1);
        code_case(CYC_IND_PTR, 1'b0, 1'b0, OP_READ, 1'b1);
        code_case(CYC_IND_PAGE, 1'b0, 1'b0, OP_READ, 1'b0);
        code_case(CYC_COND_RD_B, 1'b1, 1'b0, OP_READ, 1'b0);
        code_case(CYC_COND_RD_B, 1'b0, 1'b0, OP_NONE, 1'b0);
        code_case(CYC_COND_RD_W, 1'b1, 1'b0, OP_READ, 1'b1);
        code_case(CYC_COND_RD_W, 1'b0, 1'b0, OP_NONE, 1'b0);
        code_case(CYC_COND_WR_B, 1'b1, 1'b0, OP_WRITE, 1'b0);
        code_case(CYC_COND_WR_B, 1'b0, 1'b0, OP_NONE, 1'b0);
        page_case();
        prebyte_case();
        branch_case(1'b0, 1'b1, 1'b0, '{OP_FETCH, OP_FETCH, OP_FETCH, OP_NONE, OP_NONE, OP_NONE}, 4);
        branch_case(1'b0, 1'b0, 1'b0, '{OP_FETCH, OP_NONE, OP_NONE, OP_NONE, OP_NONE, OP_NONE}, 1);
        branch_case(1'b1, 1'b1, 1'b1, '{OP_FETCH, OP_FETCH, OP_FETCH, OP_FETCH, OP_NONE, OP_NONE}, 5);
        branch_case(1'b1, 1'b1, 1'b0, '{OP_NONE, OP_FETCH, OP_FETCH, OP_FETCH, OP_NONE, OP_NONE}, 5);
        branch_case(1'b1, 1'b0, 1'b1, '{OP_FETCH, OP_FETCH, OP_NONE, OP_NONE, OP_NONE, OP_NONE}, 3);
        branch_case(1'b1, 1'b0, 1'b0, '{OP_NONE, OP_FETCH, OP_FETCH, OP_NONE, OP_NONE, OP_NONE}, 3);
        give_verdict();
    end
endmodule : test_cpu_bus_cycle_sequencer
